// File: logic/mbs_buf2.sv
`timescale 1ns/1ps
module mbs_buf2 #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic [W-1:0] mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	logic wr;
	logic rd;

	assign in_ready_o = cnt_q != 2'h2;
	assign out_valid_o = cnt_q != 2'h0;
	assign out_data_o = mem_q[rp_q];
	assign wr = in_valid_i && in_ready_o;
	assign rd = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
	begin
		if (wr)
			mem_q[wp_q] <= in_data_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			if (wr)
				wp_q <= ~wp_q;
			if (rd)
				rp_q <= ~rp_q;
			cnt_q <= 2'(cnt_q + {1'b0, wr} - {1'b0, rd});
		end
	end
endmodule

// File: logic/mbs_pkg.sv
package mbs_pkg;
	// character framing: start + 8 data + stop
	localparam int DATA_BITS = 8;
	localparam int CHAR_BITS = 10;
	// idle gap in tenths of a character (3.5 chars)
	localparam int GAP_TENTHS = 35;
	localparam int GAP_BITS = CHAR_BITS * GAP_TENTHS / 10;
	localparam logic [5:0] GAP_END = 6'(GAP_BITS);
	localparam logic [3:0] RX_STOP = 4'(DATA_BITS + 1);
	localparam logic [3:0] TX_LEN = 4'(CHAR_BITS);
	// request layout, fixed 8 bytes for the served functions
	localparam logic [3:0] REQ_LEN = 4'h8;
	localparam int IX_ADDR = 0;
	localparam int IX_FN = 1;
	localparam int IX_A_HI = 2;
	localparam int IX_A_LO = 3;
	localparam int IX_N_HI = 4;
	localparam int IX_N_LO = 5;
	localparam logic [5:0] IX_CNT = 6'h2;
	localparam logic [5:0] IX_DATA = 6'h3;
	localparam logic [5:0] IX_DATA2 = 6'h4;
	localparam logic [7:0] MAX_ITEMS = 8'h10;
	localparam logic [4:0] ONE_BYTE_BITS = 5'h08;
	// reply lengths
	localparam logic [5:0] REP_FIXED = 6'h05;
	localparam logic [5:0] REP_WR = 6'h08;
	// function codes
	localparam logic [7:0] FN_BITS_A = 8'h01;
	localparam logic [7:0] FN_BITS_B = 8'h02;
	localparam logic [7:0] FN_REGS_A = 8'h03;
	localparam logic [7:0] FN_REGS_B = 8'h04;
	localparam logic [7:0] FN_WR_REG = 8'h06;
	// crc
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_WAIT = 2'b10,
		ST_EMIT = 2'b11
	} mbs_state_t;

	function automatic logic [15:0] mbs_crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < DATA_BITS; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

// File: logic/mbs_rtu_slave.sv
// Operation
// - frames are separated by at least 3.5 idle characters, scaled by baud
// - after 3.5 idle characters close the frame; next byte is an address
// - receiver watches the line except while driving it; fields are 8-bit bytes
// - first byte is compared with own slave address
// - bytes before the gap expires join the old frame, which then fails
// - frame is address, function, data bytes, 16-bit crc
// - bit read: 16-bit start, 16-bit count; reply with byte count and data
// - first bit in lsb of first byte, unused high bits zero
// - up to 16 bits per bit read
// - register read: reply byte count then words high byte first
// - more than 16 registers is a frame error
// - single write: perform write, then echo the request
// - crc16 from all ones, reflected polynomial, eight shifts per byte
// - no reply on crc failure
// - character: start, 8 data lsb first, no parity, one stop
// - reply echoes the function code
`timescale 1ns/1ps
module mbs_rtu_slave (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic RXD_I,
	input wire logic [7:0] SLAVE_ADDR_I,
	input wire logic [15:0] BAUD_DIV_I,
	input wire logic DATA_ACK_I,
	input wire logic [15:0] DATA_I,
	output logic TXD_O,
	output logic TX_EN_O,
	output logic DATA_REQ_O,
	output logic DATA_KIND_O,
	output logic [15:0] DATA_ADDR_O,
	output logic WR_STB_O,
	output logic [15:0] WR_ADDR_O,
	output logic [15:0] WR_DATA_O,
	output logic FRAME_OK_O,
	output logic FRAME_ERR_O
);
	logic [15:0] div_q;
	logic tick_q;
	logic rx_busy_q;
	logic [15:0] rx_cnt_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_vld_q;
	logic rx_ferr_q;
	logic [5:0] gap_q;
	logic gap_hit;
	logic [7:0] req_q [8];
	logic [3:0] fcnt_q;
	logic fbad_q;
	logic [15:0] rx_crc_q;
	logic eval;
	logic fn_bits;
	logic fn_regs;
	logic fn_wr;
	logic n_ok;
	logic frame_good;
	logic mine;
	logic fn_known;
	logic start;
	logic [5:0] nbytes;
	mbs_pkg::mbs_state_t st_q;
	logic [5:0] idx_q;
	logic [5:0] tot_q;
	logic [5:0] crc_ix;
	logic [4:0] it_q;
	logic [4:0] nit_q;
	logic kbit_q;
	logic kwr_q;
	logic have_q;
	logic [15:0] base_q;
	logic [15:0] word_q;
	logic [15:0] bits_q;
	logic [15:0] tx_crc_q;
	logic need_fetch;
	logic push_v;
	logic [7:0] push_b;
	logic push_rdy;
	logic push_fire;
	logic buf_vld;
	logic [7:0] buf_b;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_left_q;
	logic tx_idle;

	// free bit-rate divider; BAUD_DIV_I must be 2 or more
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			div_q <= 16'h0000;
			tick_q <= 1'b0;
		end
		else if (div_q == 16'h0000)
		begin
			div_q <= BAUD_DIV_I - 16'h0001;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q - 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// receiver; own echo ignored while driving the half-duplex line
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			rx_busy_q <= 1'b0;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_vld_q <= 1'b0;
			rx_ferr_q <= 1'b0;
		end
		else
		begin
			rx_vld_q <= 1'b0;
			rx_ferr_q <= 1'b0;
			if (!rx_busy_q)
			begin
				if (!RXD_I && !TX_EN_O)
				begin
					rx_busy_q <= 1'b1;
					rx_cnt_q <= {1'b0, BAUD_DIV_I[15:1]};
					rx_bit_q <= 4'h0;
				end
			end
			else if (rx_cnt_q != 16'h0000)
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			else
			begin
				rx_cnt_q <= BAUD_DIV_I - 16'h0001;
				rx_bit_q <= rx_bit_q + 4'h1;
				if (rx_bit_q == 4'h0)
				begin
					if (RXD_I)
						rx_busy_q <= 1'b0;
				end
				else if (rx_bit_q != mbs_pkg::RX_STOP)
					rx_sh_q <= {RXD_I, rx_sh_q[7:1]};
				else
				begin
					rx_busy_q <= 1'b0;
					rx_vld_q <= RXD_I;
					rx_ferr_q <= !RXD_I;
				end
			end
		end
	end

	// idle gap in bit periods, restarted by any received character
	assign gap_hit = tick_q && !rx_busy_q && gap_q == mbs_pkg::GAP_END - 6'h01;

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			gap_q <= mbs_pkg::GAP_END;
		else if (rx_busy_q)
			gap_q <= 6'h00;
		else if (tick_q && gap_q != mbs_pkg::GAP_END)
			gap_q <= gap_q + 6'h01;
	end

	// frame collection; extra bytes make the frame bad
	always_ff @(posedge CLK_I)
	begin
		if (RST_I || gap_hit)
		begin
			fcnt_q <= 4'h0;
			fbad_q <= 1'b0;
			rx_crc_q <= mbs_pkg::CRC_INIT;
		end
		else if (rx_vld_q || rx_ferr_q)
		begin
			if (fcnt_q == mbs_pkg::REQ_LEN)
				fbad_q <= 1'b1;
			else
				fcnt_q <= fcnt_q + 4'h1;
			if (rx_ferr_q)
				fbad_q <= 1'b1;
			rx_crc_q <= mbs_pkg::mbs_crc_step(rx_crc_q, rx_sh_q);
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (rx_vld_q && fcnt_q < mbs_pkg::REQ_LEN)
			req_q[fcnt_q[2:0]] <= rx_sh_q;
	end

	assign eval = gap_hit && fcnt_q != 4'h0;
	assign fn_bits = req_q[mbs_pkg::IX_FN] == mbs_pkg::FN_BITS_A
		|| req_q[mbs_pkg::IX_FN] == mbs_pkg::FN_BITS_B;
	assign fn_regs = req_q[mbs_pkg::IX_FN] == mbs_pkg::FN_REGS_A
		|| req_q[mbs_pkg::IX_FN] == mbs_pkg::FN_REGS_B;
	assign fn_wr = req_q[mbs_pkg::IX_FN] == mbs_pkg::FN_WR_REG;
	assign n_ok = req_q[mbs_pkg::IX_N_HI] == 8'h00 && req_q[mbs_pkg::IX_N_LO] != 8'h00
		&& req_q[mbs_pkg::IX_N_LO] <= mbs_pkg::MAX_ITEMS;
	assign frame_good = !fbad_q && fcnt_q == mbs_pkg::REQ_LEN
		&& rx_crc_q == mbs_pkg::CRC_RESIDUE;
	assign mine = req_q[mbs_pkg::IX_ADDR] == SLAVE_ADDR_I;
	assign fn_known = fn_wr || ((fn_bits || fn_regs) && n_ok);
	// a frame closing while a reply is still going out is dropped
	assign start = eval && frame_good && mine && fn_known && st_q == mbs_pkg::ST_IDLE;
	assign nbytes = (req_q[mbs_pkg::IX_N_LO][4:0] > mbs_pkg::ONE_BYTE_BITS) ? 6'h02 : 6'h01;

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			FRAME_OK_O <= 1'b0;
			FRAME_ERR_O <= 1'b0;
		end
		else
		begin
			FRAME_OK_O <= start;
			FRAME_ERR_O <= eval && (!frame_good || (mine && !fn_known));
		end
	end

	// reply byte selection
	assign crc_ix = tot_q - 6'h02;
	assign need_fetch = !kbit_q && !kwr_q && idx_q >= mbs_pkg::IX_DATA && idx_q[0]
		&& !have_q && idx_q < crc_ix;
	assign push_v = st_q == mbs_pkg::ST_EMIT && idx_q != tot_q && !need_fetch;
	assign push_fire = push_v && push_rdy;

	always_comb
	begin
		push_b = req_q[idx_q[2:0]];
		if (idx_q == crc_ix)
			push_b = tx_crc_q[7:0];
		else if (idx_q == crc_ix + 6'h01)
			push_b = tx_crc_q[15:8];
		else if (!kwr_q && idx_q == mbs_pkg::IX_CNT)
			push_b = kbit_q ? {2'b00, nbytes} : {2'b00, nit_q, 1'b0};
		else if (kbit_q && idx_q == mbs_pkg::IX_DATA)
			push_b = bits_q[7:0];
		else if (kbit_q && idx_q == mbs_pkg::IX_DATA2)
			push_b = bits_q[15:8];
		else if (!kwr_q && idx_q >= mbs_pkg::IX_DATA)
			push_b = idx_q[0] ? word_q[15:8] : word_q[7:0];
	end

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			st_q <= mbs_pkg::ST_IDLE;
			idx_q <= 6'h00;
			tot_q <= 6'h00;
			it_q <= 5'h00;
			nit_q <= 5'h00;
			kbit_q <= 1'b0;
			kwr_q <= 1'b0;
			have_q <= 1'b0;
			base_q <= 16'h0000;
			word_q <= 16'h0000;
			bits_q <= 16'h0000;
			DATA_REQ_O <= 1'b0;
			DATA_KIND_O <= 1'b0;
			DATA_ADDR_O <= 16'h0000;
			WR_STB_O <= 1'b0;
			WR_ADDR_O <= 16'h0000;
			WR_DATA_O <= 16'h0000;
		end
		else
		begin
			DATA_REQ_O <= 1'b0;
			WR_STB_O <= 1'b0;
			unique case (st_q)
				mbs_pkg::ST_IDLE:
					if (start)
					begin
						idx_q <= 6'h00;
						it_q <= 5'h00;
						have_q <= 1'b0;
						bits_q <= 16'h0000;
						kbit_q <= fn_bits;
						kwr_q <= fn_wr;
						nit_q <= req_q[mbs_pkg::IX_N_LO][4:0];
						base_q <= {req_q[mbs_pkg::IX_A_HI], req_q[mbs_pkg::IX_A_LO]};
						if (fn_wr)
						begin
							WR_STB_O <= 1'b1;
							WR_ADDR_O <= {req_q[mbs_pkg::IX_A_HI], req_q[mbs_pkg::IX_A_LO]};
							WR_DATA_O <= {req_q[mbs_pkg::IX_N_HI], req_q[mbs_pkg::IX_N_LO]};
							tot_q <= mbs_pkg::REP_WR;
							st_q <= mbs_pkg::ST_EMIT;
						end
						else if (fn_bits)
						begin
							tot_q <= mbs_pkg::REP_FIXED + nbytes;
							st_q <= mbs_pkg::ST_FETCH;
						end
						else
						begin
							tot_q <= mbs_pkg::REP_FIXED + {req_q[mbs_pkg::IX_N_LO][4:0], 1'b0};
							st_q <= mbs_pkg::ST_EMIT;
						end
					end
				mbs_pkg::ST_FETCH:
				begin
					DATA_REQ_O <= 1'b1;
					DATA_KIND_O <= kbit_q;
					DATA_ADDR_O <= base_q + {11'h000, it_q};
					st_q <= mbs_pkg::ST_WAIT;
				end
				mbs_pkg::ST_WAIT:
					if (DATA_ACK_I)
					begin
						it_q <= it_q + 5'h01;
						if (kbit_q)
						begin
							bits_q[it_q[3:0]] <= DATA_I[0];
							st_q <= (it_q + 5'h01 == nit_q) ? mbs_pkg::ST_EMIT : mbs_pkg::ST_FETCH;
						end
						else
						begin
							word_q <= DATA_I;
							have_q <= 1'b1;
							st_q <= mbs_pkg::ST_EMIT;
						end
					end
				mbs_pkg::ST_EMIT:
					if (idx_q == tot_q)
						st_q <= mbs_pkg::ST_IDLE;
					else if (need_fetch)
						st_q <= mbs_pkg::ST_FETCH;
					else if (push_rdy)
					begin
						idx_q <= idx_q + 6'h01;
						if (idx_q >= mbs_pkg::IX_DATA2 && !idx_q[0])
							have_q <= 1'b0;
					end
			endcase
		end
	end

	// crc of the reply, frozen while its own two bytes go out
	always_ff @(posedge CLK_I)
	begin
		if (RST_I || start)
			tx_crc_q <= mbs_pkg::CRC_INIT;
		else if (push_fire && idx_q < crc_ix)
			tx_crc_q <= mbs_pkg::mbs_crc_step(tx_crc_q, push_b);
	end

	// the buffer lets the next byte wait while a character is on the wire
	mbs_buf2 #(.W(8)) u_buf (
		.clk_i(CLK_I),
		.rst_i(RST_I),
		.in_valid_i(push_v),
		.in_ready_o(push_rdy),
		.in_data_i(push_b),
		.out_valid_o(buf_vld),
		.out_ready_i(tx_idle),
		.out_data_o(buf_b)
	);

	assign tx_idle = tx_left_q == 4'h0;

	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
		begin
			tx_sh_q <= 10'h3ff;
			tx_left_q <= 4'h0;
			TXD_O <= 1'b1;
		end
		else if (tx_idle && buf_vld)
		begin
			tx_sh_q <= {1'b1, buf_b, 1'b0};
			tx_left_q <= mbs_pkg::TX_LEN;
		end
		else if (tick_q && !tx_idle)
		begin
			TXD_O <= tx_sh_q[0];
			tx_sh_q <= {1'b1, tx_sh_q[9:1]};
			tx_left_q <= tx_left_q - 4'h1;
		end
	end

	// driver released only on a bit boundary, so the last stop bit is whole
	always_ff @(posedge CLK_I)
	begin
		if (RST_I)
			TX_EN_O <= 1'b0;
		else if (st_q != mbs_pkg::ST_IDLE || !tx_idle || buf_vld)
			TX_EN_O <= 1'b1;
		else if (tick_q)
			TX_EN_O <= 1'b0;
	end

	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	chk_gap_closes_frame: assert property (gap_hit |=> fcnt_q == 4'h0)
		else $error("frame not closed after idle gap");
	chk_bytes_join_frame: assert property ((rx_vld_q && fcnt_q < mbs_pkg::REQ_LEN)
		|=> fcnt_q == $past(fcnt_q) + 4'h1)
		else $error("byte before gap not appended");
	chk_crc_fail_silent: assert property ((eval && rx_crc_q != mbs_pkg::CRC_RESIDUE)
		|=> FRAME_ERR_O && !FRAME_OK_O && st_q == mbs_pkg::ST_IDLE)
		else $error("reply started on crc failure");
	chk_foreign_silent: assert property ((eval && !mine)
		|=> !FRAME_OK_O && st_q == mbs_pkg::ST_IDLE)
		else $error("reply to foreign address");
	chk_reg_limit: assert property ((eval && frame_good && mine && fn_regs
		&& req_q[mbs_pkg::IX_N_LO] > mbs_pkg::MAX_ITEMS) |=> FRAME_ERR_O)
		else $error("register count over limit accepted");
	chk_bit_limit: assert property ((eval && frame_good && mine && fn_bits
		&& req_q[mbs_pkg::IX_N_LO] > mbs_pkg::MAX_ITEMS) |=> FRAME_ERR_O)
		else $error("bit count over limit accepted");
	chk_fn_echo: assert property ((push_fire && idx_q == 6'h01)
		|-> push_b == req_q[mbs_pkg::IX_FN])
		else $error("function code not echoed");
	chk_write_first: assert property (WR_STB_O
		|-> st_q == mbs_pkg::ST_EMIT && idx_q == 6'h00 && !buf_vld)
		else $error("write not ahead of reply");
	chk_pad_zero: assert property ((start && fn_bits) |=> bits_q == 16'h0000)
		else $error("bit reply not zero padded");
	chk_crc_seed: assert property (start |=> tx_crc_q == mbs_pkg::CRC_INIT)
		else $error("reply crc not seeded");
	chk_start_bit: assert property ((tick_q && tx_left_q == mbs_pkg::TX_LEN)
		|=> !TXD_O && TX_EN_O)
		else $error("character without start bit");

	// a write echo needs several character times before the pusher goes idle
	cov_write_reply: cover property (WR_STB_O ##[1:1000] st_q == mbs_pkg::ST_IDLE);
	cov_bit_reply: cover property (start && fn_bits);
	cov_reg_reply: cover property (start && fn_regs && req_q[mbs_pkg::IX_N_LO] == 8'h10);
	cov_buffer_full: cover property (push_v && !push_rdy);
endmodule

// File: sim/mbs_master_model.sv
`timescale 1ns/1ps
module mbs_master_model (
	input wire logic clk_i,
	input wire logic [15:0] div_i,
	input wire logic line_txd_i,
	input wire logic line_en_i,
	output logic line_rxd_o
);
	logic [7:0] rx_q[$];
	logic line;
	// bias resistors pull an undriven bus to the idle level
	assign line = (line_en_i === 1'b1) ? line_txd_i : 1'b1;
	initial line_rxd_o = 1'b1;

	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			line_rxd_o = f[i];
			repeat (div_i) @(negedge clk_i);
		end
	endtask

	// bytes go back to back, no gap inside a frame
	task automatic send_frame(input logic [7:0] q[$]);
		@(negedge clk_i);
		foreach (q[i])
			send_byte(q[i]);
	endtask

	task automatic idle_gap(input int chars);
		repeat (chars * 10 * div_i) @(negedge clk_i);
	endtask

	// a bad stop bit leaves an unknown byte so that any compare fails
	initial
	begin
		logic [7:0] b;
		forever
		begin
			@(negedge line);
			repeat (div_i / 2) @(posedge clk_i);
			for (int i = 0; i < 8; i++)
			begin
				repeat (div_i) @(posedge clk_i);
				b[i] = line;
			end
			repeat (div_i) @(posedge clk_i);
			rx_q.push_back((line === 1'b1) ? b : 8'bx);
		end
	end
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic CLK_I, RST_I, RXD_I, DATA_ACK_I, TXD_O, TX_EN_O, DATA_REQ_O, DATA_KIND_O;
	logic WR_STB_O, FRAME_OK_O, FRAME_ERR_O;
	logic [7:0] SLAVE_ADDR_I;
	logic [15:0] BAUD_DIV_I, DATA_I, DATA_ADDR_O, WR_ADDR_O, WR_DATA_O;
	int n_fail, n_compared, n_ok, n_err, n_wr;
	integer seed = 32'h47da0721;
	logic [15:0] exp_addr, last_wa, last_wd;
	logic exp_kind;
	logic [7:0] req[$];
	logic [7:0] exp[$];
	logic [7:0] fns[5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};

	initial
	begin
		CLK_I = 1'b0;
		forever #5 CLK_I = ~CLK_I;
	end

	mbs_rtu_slave u_mbs_rtu_slave (.CLK_I(CLK_I), .RST_I(RST_I), .RXD_I(RXD_I),
		.SLAVE_ADDR_I(SLAVE_ADDR_I), .BAUD_DIV_I(BAUD_DIV_I), .DATA_ACK_I(DATA_ACK_I),
		.DATA_I(DATA_I), .TXD_O(TXD_O), .TX_EN_O(TX_EN_O), .DATA_REQ_O(DATA_REQ_O),
		.DATA_KIND_O(DATA_KIND_O), .DATA_ADDR_O(DATA_ADDR_O), .WR_STB_O(WR_STB_O),
		.WR_ADDR_O(WR_ADDR_O), .WR_DATA_O(WR_DATA_O), .FRAME_OK_O(FRAME_OK_O),
		.FRAME_ERR_O(FRAME_ERR_O));

	mbs_master_model u_mbs_master_model (.clk_i(CLK_I), .div_i(BAUD_DIV_I),
		.line_txd_i(TXD_O), .line_en_i(TX_EN_O), .line_rxd_o(RXD_I));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	function automatic logic [15:0] mem_val(input logic [15:0] a);
		return (a * 16'h9e37) ^ 16'h5a5a;
	endfunction

	function automatic void add_crc(ref logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endfunction

	function automatic void mk_req(input logic [7:0] sa, input logic [7:0] fn,
		input logic [15:0] a, input logic [15:0] n);
		req = {sa, fn, a[15:8], a[7:0], n[15:8], n[7:0]};
		add_crc(req);
	endfunction

	function automatic void mk_exp();
		logic [15:0] a, n, v;
		logic [7:0] b;
		a = {req[2], req[3]};
		n = {req[4], req[5]};
		exp = {req[0], req[1]};
		if (req[1] == 8'h06)
		begin
			exp = req;
			return;
		end
		if (req[1] < 8'h03)
		begin
			exp.push_back(8'((n + 7) / 8));
			for (int k = 0; k < (n + 7) / 8; k++)
			begin
				b = 8'h00;
				for (int j = 0; j < 8; j++)
				begin
					v = mem_val(a + 16'(8 * k + j));
					if (8 * k + j < n)
						b[j] = v[0];
				end
				exp.push_back(b);
			end
		end
		else
		begin
			exp.push_back(8'(2 * n));
			for (int i = 0; i < n; i++)
			begin
				v = mem_val(a + 16'(i));
				exp.push_back(v[15:8]);
				exp.push_back(v[7:0]);
			end
		end
		add_crc(exp);
	endfunction

	// kind 0 answered, 1 refused with an error pulse, 2 ignored silently
	task automatic run(input int kind);
		int ok0, err0, wr0;
		ok0 = n_ok;
		err0 = n_err;
		wr0 = n_wr;
		exp = {};
		if (kind == 0)
			mk_exp();
		u_mbs_master_model.rx_q.delete();
		exp_addr = {req[2], req[3]};
		exp_kind = (req[1] < 8'h03);
		u_mbs_master_model.send_frame(req);
		u_mbs_master_model.idle_gap(4);
		for (int i = 0; i < 20000 && u_mbs_master_model.rx_q.size() < exp.size(); i++)
			@(negedge CLK_I);
		for (int i = 0; i < 2000 && TX_EN_O !== 1'b0; i++)
			@(negedge CLK_I);
		u_mbs_master_model.idle_gap(4);
		chk("ok pulses", n_ok - ok0, kind == 0);
		chk("err pulses", n_err - err0, kind == 1);
		chk("reply length", u_mbs_master_model.rx_q.size(), exp.size());
		foreach (exp[i])
			chk("reply byte", u_mbs_master_model.rx_q[i], exp[i]);
		chk("write strobes", n_wr - wr0, kind == 0 && req[1] == 8'h06);
		if (kind == 0 && req[1] == 8'h06)
		begin
			chk("write address", last_wa, {req[2], req[3]});
			chk("write value", last_wd, {req[4], req[5]});
		end
		$display("test done fn %h kind %0d", req[1], kind);
	endtask

	// item source answers each request after a random delay
	initial
	begin
		DATA_ACK_I = 1'b0;
		DATA_I = 16'h0000;
		forever
		begin
			@(negedge CLK_I);
			if (DATA_REQ_O === 1'b1)
			begin
				chk("item address", DATA_ADDR_O, exp_addr);
				chk("item kind", DATA_KIND_O, exp_kind);
				exp_addr = exp_addr + 16'h0001;
				repeat ($unsigned($random(seed)) % 4) @(negedge CLK_I);
				DATA_I = mem_val(DATA_ADDR_O);
				DATA_ACK_I = 1'b1;
				@(negedge CLK_I);
				DATA_ACK_I = 1'b0;
			end
		end
	end

	always @(negedge CLK_I)
	begin
		n_ok += (FRAME_OK_O === 1'b1);
		n_err += (FRAME_ERR_O === 1'b1);
		if (WR_STB_O === 1'b1)
		begin
			n_wr++;
			last_wa = WR_ADDR_O;
			last_wd = WR_DATA_O;
		end
	end

	initial
	begin
		repeat (95000) @(posedge CLK_I);
		n_fail++;
		$display("ERROR watchdog expected finish seen timeout");
		test_done();
	end

	initial
	begin
		RST_I = 1'b1;
		SLAVE_ADDR_I = 8'h11;
		BAUD_DIV_I = 16'h0008;
		repeat (6) @(negedge CLK_I);
		RST_I = 1'b0;
		u_mbs_master_model.idle_gap(4);
		for (int t = 0; t < 8; t++)
		begin
			BAUD_DIV_I = t[0] ? 16'h000c : 16'h0008;
			SLAVE_ADDR_I = 8'h01 + 8'($unsigned($random(seed)) % 247);
			mk_req(SLAVE_ADDR_I, fns[t % 5], 16'($random(seed)),
				(t % 5 == 4) ? 16'($random(seed)) : 16'h0001 + 16'($unsigned($random(seed)) % 16));
			run(0);
		end
		BAUD_DIV_I = 16'h0008;
		mk_req(SLAVE_ADDR_I, 8'h01, 16'hfff8, 16'h0010);
		run(0);
		mk_req(SLAVE_ADDR_I, 8'h02, 16'h0003, 16'h0009);
		run(0);
		mk_req(SLAVE_ADDR_I, 8'h04, 16'h0100, 16'h0010);
		run(0);
		mk_req(SLAVE_ADDR_I, 8'h03, 16'h0100, 16'h0011);
		run(1);
		mk_req(SLAVE_ADDR_I, 8'h03, 16'h0100, 16'h0000);
		run(1);
		mk_req(SLAVE_ADDR_I, 8'h05, 16'h0001, 16'hff00);
		run(1);
		mk_req(SLAVE_ADDR_I, 8'h01, 16'h0000, 16'h0011);
		run(1);
		mk_req(SLAVE_ADDR_I, 8'h03, 16'h0000, 16'h0002);
		void'(req.pop_back());
		run(1);
		mk_req(SLAVE_ADDR_I + 8'h01, 8'h03, 16'h0000, 16'h0002);
		run(2);
		mk_req(SLAVE_ADDR_I, 8'h06, 16'h0001, 16'h000f);
		req[7] = req[7] ^ 8'h01;
		run(1);
		mk_req(SLAVE_ADDR_I, 8'h03, 16'h0000, 16'h0002);
		u_mbs_master_model.send_frame(req);
		u_mbs_master_model.idle_gap(1);
		run(1);
		mk_req(SLAVE_ADDR_I, 8'h06, 16'h0001, 16'h000f);
		run(0);
		test_done();
	end
endmodule
